// ==== logic/elg_cfg_if.sv ====
// ----------------------------------------------------------------------
// Carrier between indirect access, global registers and port timers
// ----------------------------------------------------------------------
interface elg_cfg_if;
	logic wr_stb;
	logic [7:0] offset;
	logic [7:0] wdata;
	logic [7:0] rbyte;
	logic term_en;
	logic [15:0] wait_time;

	modport regfile (
		input wr_stb,
		input offset,
		input wdata,
		output rbyte,
		output term_en,
		output wait_time
	);

	modport access (
		output wr_stb,
		output offset,
		output wdata,
		input rbyte
	);

	modport timer (
		input term_en,
		input wait_time
	);
endinterface

// ==== logic/elg_pkg.sv ====
// ----------------------------------------------------------------------
// Shared constants for the EEE global low power idle control
// ----------------------------------------------------------------------
package elg_pkg;

	// Direct byte addresses of the indirect access window
	localparam logic [7:0] ADDR_IND_CTRL = 8'h6e;
	localparam logic [7:0] ADDR_IND_OFFSET = 8'h6f;
	localparam logic [7:0] ADDR_IND_DATA = 8'ha0;

	// Field layout of the indirect control byte
	localparam int TABLE_MSB = 7;
	localparam int TABLE_LSB = 5;
	localparam int PORT_MSB = 3;
	localparam int PORT_LSB = 0;

	// Selection code of the global EEE table
	localparam logic [2:0] TABLE_EEE = 3'h1;
	localparam logic [3:0] PORT_GLOBAL = 4'h0;

	// Byte offsets inside the global EEE table
	localparam logic [7:0] OFS_BUF_HI = 8'h30;
	localparam logic [7:0] OFS_BUF_LO = 8'h31;
	localparam logic [7:0] OFS_WAIT_HI = 8'h32;
	localparam logic [7:0] OFS_WAIT_LO = 8'h33;

	// Fixed read values and reset values
	localparam logic [7:0] BUF_HI_RO = 8'h40;
	localparam logic [6:0] BUF_LO_RO = 7'h10;
	localparam int TERM_EN_BIT = 7;
	localparam logic TERM_EN_RESET = 1'b0;
	localparam logic [15:0] WAIT_RESET = 16'h0010;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] OFFSET_RESET = 8'h00;

	// Wait time step and its length in clock cycles
	localparam int STEP_TIME_NS = 1300000;
	localparam int CLK_PERIOD_NS = 100;
	localparam int STEP_CYCLES = (STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Per-port idle request sequence
	typedef enum logic [1:0] {
		ELG_IDLE = 2'b00,
		ELG_COUNT = 2'b01,
		ELG_REQ = 2'b11
	} elg_lpi_state_type;

endpackage

// ==== logic/elg_port_timer.sv ====
// ----------------------------------------------------------------------
// Empty queue timer and idle request for one copper port
// ----------------------------------------------------------------------
module elg_port_timer (
	// Clock, reset, enable
	input wire logic clock_in,
	input wire logic arst_n_in,
	input wire logic ce_in,
	// Shared step pulse and configuration
	input wire logic step_in,
	elg_cfg_if.timer cfg,
	// Port status
	input wire logic queue_empty_in,
	input wire logic input_traffic_in,
	input wire logic eee_100bt_en_in,
	// Idle request
	output logic lpi_req_out
);

	elg_pkg::elg_lpi_state_type state_reg, state_next;
	logic [15:0] cnt_reg, cnt_next;
	logic req_reg;

	// Conditions that restart the wait
	wire cancel = cfg.term_en && input_traffic_in;
	wire restart = !eee_100bt_en_in || !queue_empty_in || cancel;
	// Wait lowered during a count ends it at the next step, no wrap
	wire cnt_done = (cnt_reg >= cfg.wait_time);

	// Next state: one more step after the wait time means it is exceeded
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		if (restart) begin
			state_next = elg_pkg::ELG_IDLE;
			cnt_next = '0;
		end else begin
			unique case (state_reg)
				elg_pkg::ELG_IDLE: begin
					state_next = elg_pkg::ELG_COUNT;
					cnt_next = '0;
				end
				elg_pkg::ELG_COUNT: begin
					if (step_in) begin
						if (cnt_done) begin
							state_next = elg_pkg::ELG_REQ;
						end else begin
							cnt_next = cnt_reg + 16'h0001;
						end
					end
				end
				elg_pkg::ELG_REQ: begin
					state_next = elg_pkg::ELG_REQ;
				end
				default: begin
					state_next = elg_pkg::ELG_IDLE;
				end
			endcase
		end
	end

	// State, counter and registered request
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state_reg <= elg_pkg::ELG_IDLE;
			cnt_reg <= '0;
			req_reg <= 1'b0;
		end else if (ce_in) begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			req_reg <= (state_next == elg_pkg::ELG_REQ);
		end
	end

	assign lpi_req_out = req_reg;

endmodule

// ==== logic/elg_regfile.sv ====
// ----------------------------------------------------------------------
// Global EEE registers behind the indirect window
// ----------------------------------------------------------------------
module elg_regfile (
	// Clock, reset, enable
	input wire logic clock_in,
	input wire logic arst_n_in,
	input wire logic ce_in,
	// Indirect access and configuration
	elg_cfg_if.regfile cfg
);

	logic term_en_reg;
	logic [15:0] wait_reg;

	// Write decode per byte offset
	wire wr_buf_lo = cfg.wr_stb && (cfg.offset == elg_pkg::OFS_BUF_LO);
	wire wr_wait_hi = cfg.wr_stb && (cfg.offset == elg_pkg::OFS_WAIT_HI);
	wire wr_wait_lo = cfg.wr_stb && (cfg.offset == elg_pkg::OFS_WAIT_LO);

	// Writable fields; reserved bits are not stored
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			term_en_reg <= elg_pkg::TERM_EN_RESET;
			wait_reg <= elg_pkg::WAIT_RESET;
		end else if (ce_in) begin
			if (wr_buf_lo) begin
				term_en_reg <= cfg.wdata[elg_pkg::TERM_EN_BIT];
			end
			if (wr_wait_hi) begin
				wait_reg[15:8] <= cfg.wdata;
			end
			if (wr_wait_lo) begin
				wait_reg[7:0] <= cfg.wdata;
			end
		end
	end

	// Read byte selection, reserved fields read fixed values
	wire [7:0] buf_lo_byte = {term_en_reg, elg_pkg::BUF_LO_RO};
	assign cfg.rbyte = (cfg.offset == elg_pkg::OFS_BUF_HI) ? elg_pkg::BUF_HI_RO :
		(cfg.offset == elg_pkg::OFS_BUF_LO) ? buf_lo_byte :
		(cfg.offset == elg_pkg::OFS_WAIT_HI) ? wait_reg[15:8] :
		(cfg.offset == elg_pkg::OFS_WAIT_LO) ? wait_reg[7:0] :
		elg_pkg::BYTE_ZERO;

	// One shared copy for all copper ports
	assign cfg.term_en = term_en_reg;
	assign cfg.wait_time = wait_reg;

endmodule

// ==== logic/elg_top.sv ====
// Function
// - Idle control serves copper ports only
// - EEE registers reached only by indirect access
// - Select table 001, port 0, then offset
// - Data byte register reads and writes selection
// - Buffer control at offsets 0x30 and 0x31
// - Enable bit 7 lets traffic cancel request
// - Wait time at offsets 0x32 and 0x33
// - Request only after queue empty beyond wait
// - Wait time counts in 1.3 ms steps
// - Wait time used only with 100BT EEE
// - One wait time shared by all ports
module elg_top #(
	parameter int NUM_PORTS = 4,
	parameter int STEP_CYCLES = elg_pkg::STEP_CYCLES
) (
	// Clock, reset, enable
	input wire logic clock_in,
	input wire logic arst_n_in,
	input wire logic ce_in,
	// Byte register port
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [7:0] reg_rdata_out,
	// Copper port status
	input wire logic [NUM_PORTS-1:0] queue_empty_in,
	input wire logic [NUM_PORTS-1:0] input_traffic_in,
	input wire logic [NUM_PORTS-1:0] eee_100bt_en_in,
	// Idle requests
	output logic [NUM_PORTS-1:0] lpi_req_out
);

	// ----------------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------------
	localparam int STEP_W = (STEP_CYCLES > 1) ? $clog2(STEP_CYCLES) : 1;
	localparam logic [STEP_W-1:0] STEP_LAST = STEP_W'(STEP_CYCLES - 1);
	localparam logic [STEP_W-1:0] STEP_ONE = STEP_W'(1);

	if (NUM_PORTS < 1 || NUM_PORTS > 15) begin : g_bad_ports
		$error("NUM_PORTS out of range");
	end
	if (STEP_CYCLES < 2) begin : g_bad_step
		$error("STEP_CYCLES must be at least 2");
	end

	// ----------------------------------------------------------------------
	// Indirect selection
	// ----------------------------------------------------------------------
	elg_cfg_if cfg ();

	logic [7:0] ctrl_reg;
	logic [7:0] offset_reg;
	logic [7:0] rdata_reg;

	// Direct address decode
	wire hit_ctrl = (reg_addr_in == elg_pkg::ADDR_IND_CTRL);
	wire hit_offset = (reg_addr_in == elg_pkg::ADDR_IND_OFFSET);
	wire hit_data = (reg_addr_in == elg_pkg::ADDR_IND_DATA);

	// Table and port fields of the selection
	wire [2:0] sel_table = ctrl_reg[elg_pkg::TABLE_MSB:elg_pkg::TABLE_LSB];
	wire [3:0] sel_port = ctrl_reg[elg_pkg::PORT_MSB:elg_pkg::PORT_LSB];
	wire global_sel = (sel_table == elg_pkg::TABLE_EEE) &&
		(sel_port == elg_pkg::PORT_GLOBAL);

	// Selection registers
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ctrl_reg <= elg_pkg::CTRL_RESET;
			offset_reg <= elg_pkg::OFFSET_RESET;
		end else if (ce_in && reg_wr_in) begin
			if (hit_ctrl) begin
				ctrl_reg <= reg_wdata_in;
			end
			if (hit_offset) begin
				offset_reg <= reg_wdata_in;
			end
		end
	end

	// Data byte writes reach the global table only when it is selected
	assign cfg.wr_stb = ce_in && reg_wr_in && hit_data && global_sel;
	assign cfg.offset = offset_reg;
	assign cfg.wdata = reg_wdata_in;

	// ----------------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------------
	wire [7:0] ind_byte = global_sel ? cfg.rbyte : elg_pkg::BYTE_ZERO;
	wire [7:0] rd_next = hit_ctrl ? ctrl_reg :
		hit_offset ? offset_reg :
		hit_data ? ind_byte :
		elg_pkg::BYTE_ZERO;

	// Read data is captured on the read strobe and held
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rdata_reg <= elg_pkg::BYTE_ZERO;
		end else if (ce_in && reg_rd_in) begin
			rdata_reg <= rd_next;
		end
	end

	assign reg_rdata_out = rdata_reg;

	// ----------------------------------------------------------------------
	// Global registers
	// ----------------------------------------------------------------------
	elg_regfile u_regfile (
		.clock_in(clock_in),
		.arst_n_in(arst_n_in),
		.ce_in(ce_in),
		.cfg(cfg)
	);

	// ----------------------------------------------------------------------
	// Wait time step generator
	// ----------------------------------------------------------------------
	logic [STEP_W-1:0] step_cnt_reg;

	wire step = (step_cnt_reg == STEP_LAST);

	// Free running divider shared by all ports
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			step_cnt_reg <= '0;
		end else if (ce_in) begin
			step_cnt_reg <= step ? '0 : step_cnt_reg + STEP_ONE;
		end
	end

	// ----------------------------------------------------------------------
	// Copper port timers; the uplink port has no timer
	// ----------------------------------------------------------------------
	for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
		elg_port_timer u_timer (
			.clock_in(clock_in),
			.arst_n_in(arst_n_in),
			.ce_in(ce_in),
			.step_in(step),
			.cfg(cfg),
			.queue_empty_in(queue_empty_in[p]),
			.input_traffic_in(input_traffic_in[p]),
			.eee_100bt_en_in(eee_100bt_en_in[p]),
			.lpi_req_out(lpi_req_out[p])
		);
	end

endmodule

// ==== sim/elg_top_assertions.sv ====
module elg_top_assertions #(
	parameter int NUM_PORTS = 4,
	parameter int STEP_CYCLES = 4
) (
	// Clock, reset, enable
	input wire logic clock_in,
	input wire logic arst_n_in,
	input wire logic ce_in,
	// Byte register port
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [7:0] reg_rdata_out,
	// Port status and requests
	input wire logic [NUM_PORTS-1:0] queue_empty_in,
	input wire logic [NUM_PORTS-1:0] input_traffic_in,
	input wire logic [NUM_PORTS-1:0] eee_100bt_en_in,
	input wire logic [NUM_PORTS-1:0] lpi_req_out
);
	timeunit 1ns;
	timeprecision 1ns;

	// Shadow of the selection bytes
	logic [7:0] ctl_reg;
	logic [7:0] ofs_reg;
	wire logic wr_ok = ce_in && reg_wr_in;
	wire logic rd_ok = ce_in && reg_rd_in;
	wire logic dir_hit = reg_addr_in == 8'h6e || reg_addr_in == 8'h6f || reg_addr_in == 8'ha0;
	wire logic sel_ok = ctl_reg[7:5] == 3'h1 && ctl_reg[3:0] == 4'h0;
	wire logic rd_dat = rd_ok && reg_addr_in == 8'ha0;

	// Track the last written control and offset bytes
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ctl_reg <= 8'h00;
			ofs_reg <= 8'h00;
		end else begin
			if (wr_ok && reg_addr_in == 8'h6e) ctl_reg <= reg_wdata_in;
			if (wr_ok && reg_addr_in == 8'h6f) ofs_reg <= reg_wdata_in;
		end
	end

	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!arst_n_in);

	// Register port relations
	chk_unmapped_zero: assert property (rd_ok && !dir_hit |=> reg_rdata_out == 8'h00)
		else $error("unmapped read not zero");
	chk_rdata_hold: assert property (!rd_ok |=> $stable(reg_rdata_out))
		else $error("read data changed without read");
	chk_ctrl_readback: assert property (rd_ok && reg_addr_in == 8'h6e |=> reg_rdata_out == $past(ctl_reg))
		else $error("control byte readback wrong");
	chk_unsel_data: assert property (rd_dat && !sel_ok |=> reg_rdata_out == 8'h00)
		else $error("unselected table read not zero");
	chk_buf_hi_fixed: assert property (rd_dat && sel_ok && ofs_reg == 8'h30 |=> reg_rdata_out == 8'h40)
		else $error("buffer control upper byte wrong");
	chk_buf_lo_fixed: assert property (rd_dat && sel_ok && ofs_reg == 8'h31 |=> reg_rdata_out[6:0] == 7'h10)
		else $error("buffer control reserved bits wrong");

	// Idle request relations
	chk_req_keep: assert property (ce_in |=> (~lpi_req_out & $past(lpi_req_out & queue_empty_in & eee_100bt_en_in & ~input_traffic_in)) == '0)
		else $error("request dropped without cause");
	chk_req_empty: assert property (ce_in |=> (lpi_req_out & ~$past(queue_empty_in)) == '0)
		else $error("request with busy queue");
	chk_req_eee_on: assert property (ce_in |=> (lpi_req_out & ~$past(eee_100bt_en_in)) == '0)
		else $error("request with EEE disabled");
	chk_freeze_req: assert property (!ce_in |=> $stable(lpi_req_out))
		else $error("request changed while disabled");
endmodule

bind elg_top elg_top_assertions #(.NUM_PORTS(NUM_PORTS), .STEP_CYCLES(STEP_CYCLES)) u_elg_top_assertions (
	.clock_in(clock_in), .arst_n_in(arst_n_in), .ce_in(ce_in), .reg_addr_in(reg_addr_in),
	.reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
	.reg_rdata_out(reg_rdata_out), .queue_empty_in(queue_empty_in),
	.input_traffic_in(input_traffic_in), .eee_100bt_en_in(eee_100bt_en_in),
	.lpi_req_out(lpi_req_out));

// ==== sim/elg_top_tb.sv ====
module elg_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock_in = 1'b0;
	logic arst_n_in = 1'b0;
	logic ce_in = 1'b1;
	logic [7:0] reg_addr_in = 8'h00;
	logic [7:0] reg_wdata_in = 8'h00;
	logic reg_wr_in = 1'b0;
	logic reg_rd_in = 1'b0;
	logic [7:0] reg_rdata_out;
	logic [3:0] queue_empty_in = 4'h0;
	logic [3:0] input_traffic_in = 4'h0;
	logic [3:0] eee_100bt_en_in = 4'h0;
	logic [3:0] lpi_req_out;
	logic [7:0] exp_q[$];
	logic rd_pend = 1'b0;
	logic [31:0] seed = 32'h25d3;
	int error_cnt = 0;
	int n_compared = 0;

	// Clock
	initial begin
		forever #50 clock_in = ~clock_in;
	end

	elg_top #(.NUM_PORTS(4), .STEP_CYCLES(4)) u_elg_top (
		.clock_in(clock_in), .arst_n_in(arst_n_in), .ce_in(ce_in), .reg_addr_in(reg_addr_in),
		.reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
		.reg_rdata_out(reg_rdata_out), .queue_empty_in(queue_empty_in),
		.input_traffic_in(input_traffic_in), .eee_100bt_en_in(eee_100bt_en_in),
		.lpi_req_out(lpi_req_out));

	// Helpers
	function automatic logic [31:0] xs(input logic [31:0] v);
		logic [31:0] t;
		t = v ^ (v << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic give_verdict();
		if (error_cnt == 0 && n_compared > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge clock_in);
	endtask

	// One strobed byte access
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(negedge clock_in);
		reg_addr_in = a;
		reg_wdata_in = d;
		reg_wr_in = w;
		reg_rd_in = !w;
		@(negedge clock_in);
		reg_wr_in = 1'b0;
		reg_rd_in = 1'b0;
	endtask

	task automatic iwr(input logic [7:0] o, input logic [7:0] d);
		acc(1'b1, 8'h6e, 8'h20);
		acc(1'b1, 8'h6f, o);
		acc(1'b1, 8'ha0, d);
	endtask

	task automatic ird(input logic [7:0] o, input logic [7:0] e);
		acc(1'b1, 8'h6e, 8'h20);
		acc(1'b1, 8'h6f, o);
		exp_q.push_back(e);
		acc(1'b0, 8'ha0, 8'h00);
	endtask

	// Read result monitor
	always @(posedge clock_in) begin
		rd_pend <= ce_in && reg_rd_in;
	end
	always @(negedge clock_in) begin
		if (rd_pend) chk(reg_rdata_out, exp_q.pop_front());
	end

	// Watchdog
	initial begin
		repeat (5000) @(posedge clock_in);
		error_cnt++;
		give_verdict();
	end

	// Main sequence
	initial begin
		cyc(4);
		arst_n_in = 1'b1;
		ird(8'h30, 8'h40);
		ird(8'h31, 8'h10);
		ird(8'h32, 8'h00);
		ird(8'h33, 8'h10);
		exp_q.push_back(8'h00);
		acc(1'b0, 8'h55, 8'h00);
		ird(8'h34, 8'h00);
		iwr(8'h30, 8'h40);
		ird(8'h30, 8'h40);
		seed = xs(seed);
		iwr(8'h32, seed[7:0]);
		ird(8'h32, seed[7:0]);
		for (int i = 0; i < 2; i++) begin
			acc(1'b1, 8'h6e, i ? 8'h21 : 8'h40);
			exp_q.push_back(8'h00);
			acc(1'b0, 8'ha0, 8'h00);
		end
		exp_q.push_back(8'h21);
		acc(1'b0, 8'h6e, 8'h00);
		iwr(8'h32, 8'h00);
		iwr(8'h33, 8'h02);
		eee_100bt_en_in = 4'h7;
		queue_empty_in = 4'hf;
		cyc(7);
		chk({4'h0, lpi_req_out}, 8'h00);
		cyc(8);
		chk({4'h0, lpi_req_out}, 8'h07);
		input_traffic_in = 4'h1;
		cyc(2);
		chk({4'h0, lpi_req_out}, 8'h07);
		ce_in = 1'b0;
		queue_empty_in = 4'he;
		cyc(3);
		chk({4'h0, lpi_req_out}, 8'h07);
		ce_in = 1'b1;
		cyc(2);
		chk({4'h0, lpi_req_out}, 8'h06);
		queue_empty_in = 4'hf;
		input_traffic_in = 4'h0;
		iwr(8'h31, 8'h90);
		ird(8'h31, 8'h90);
		cyc(4);
		input_traffic_in = 4'h2;
		cyc(2);
		chk({4'h0, lpi_req_out}, 8'h05);
		arst_n_in = 1'b0;
		cyc(1);
		chk({4'h0, lpi_req_out}, 8'h00);
		arst_n_in = 1'b1;
		ird(8'h33, 8'h10);
		cyc(40);
		chk({4'h0, lpi_req_out}, 8'h00);
		// Lower the wait below the running count: request at the next step
		iwr(8'h33, 8'h02);
		cyc(6);
		chk({4'h0, lpi_req_out}, 8'h07);
		give_verdict();
	end
endmodule
